// [csc_clock_source_ctrl.v]
// Clock source control and status block with an APB register slave.
`timescale 1ns/1ns
`include "csc_regs.vh"

// Operation
// R1: Bus clock divides selected clock by 1, 2, 4 or 8 per divider code.
// R2: Divider field resets to code 01, divide by two.
// R3: Range bit 1 selects high oscillator range, 0 selects low range.
// R4: Gain bit 1 selects high gain, 0 selects low power oscillator.
// R5: Low power bit disables loop in bypass modes unless debug is active.
// R6: Request bit 1 asks for crystal oscillator, 0 for external clock.
// R7: Output enable bit drives external reference clock out, else held inactive.
// R8: In stop, reference kept only if stop-keep set and enable set before stop.
// R9: Coarse trim loads factory value at reset, or 0x80 in debug mode.
// R10: Eight-bit coarse trim sets reference period; larger means longer period.
// R11: Range status follows controlled oscillator only after synchronization.
// R12: Range select write of 11 is ignored; status keeps its setting.
// R13: Range select writes ignored while low power bit is set.
// R14: Range codes 00 low, 01 mid, 10 high, 11 reserved.
// R15: Tuning off gives loop factors 512, 1024, 1536 per range.
// R16: Tuning on gives loop factors 608, 1216, 1824 per range.
// R17: Reference status reads 0 external, 1 internal, after synchronization.
// R18: Clock mode status shows active source, after synchronization.
// R19: Ready flag sets after oscillator init when external reference requested.
// R20: Ready flag clears only when enable or request bit is cleared.
// R21: Fine trim bit set lengthens period, clear shortens, smallest step.
// R22: Fine trim loads factory value at reset, or 0 in debug mode.
// R23: Source select 00 loop, 01 internal, 10 external, 11 reserved.
// R24: Internal bypass low power when 01, internal, no debug, low power set.
// R25: Status fields pass two synchronizer flip-flops before software sees them.
module csc_clock_source_ctrl (
  input  wire        i_clk,             // Block clock, 10 MHz.
  input  wire        i_rst_n,           // Synchronous reset, active low.
  input  wire        i_psel,            // APB select.
  input  wire        i_penable,         // APB enable.
  input  wire        i_pwrite,          // APB write direction.
  input  wire [11:0] i_paddr,           // APB byte address.
  input  wire [31:0] i_pwdata,          // APB write data.
  output reg  [31:0] o_prdata,          // APB read data.
  output reg         o_pready,          // APB ready.
  output reg         o_pslverr,         // APB error on unmapped address.
  input  wire        i_debug_halt_mode, // Debug mode active, async pin.
  input  wire        i_stop_mode,       // Device in stop, async pin.
  input  wire        i_osc_clock_signal,// Oscillator running indication, async pin.
  input  wire [7:0]  i_factory_trim,    // Factory coarse trim value.
  input  wire        i_factory_fine_period_adjust,   // Factory fine trim value.
  input  wire        i_sel_clk_tick,    // One-cycle tick of the selected source clock.
  output reg         o_bus_clk_en,      // Bus clock enable pulse.
  output reg         o_osc_high_range,  // Oscillator high range select.
  output reg         o_high_gain_osc_select, // Oscillator high gain select.
  output reg         o_ext_ref_osc_request,  // Crystal requested when high.
  output reg         o_ext_ref_clock_out,    // External reference clock output active.
  output reg         o_ext_ref_enable,       // External reference source enabled.
  output reg         o_loop_enable,          // Frequency-locked loop enabled.
  output reg  [10:0] o_loop_factor,          // Loop multiplication factor.
  output reg  [1:0]  o_controlled_osc_range, // Range applied to the oscillator.
  output reg  [7:0]  o_coarse_trim,          // Coarse period trim.
  output reg         o_fine_period_adjust    // Fine period trim.
);

  // Loop multiplication factor lookup for a range and tuning option.
  // The reserved range code falls to the low factor; the select path never stores it.
  function [10:0] csc_factor;
    input [1:0] rng;
    input       tune;
    begin
      case (rng)
        `CSC_RANGE_MID:  csc_factor = tune ? `CSC_FACT32_MID  : `CSC_FACT_MID;
        `CSC_RANGE_HIGH: csc_factor = tune ? `CSC_FACT32_HIGH : `CSC_FACT_HIGH;
        default:         csc_factor = tune ? `CSC_FACT32_LOW  : `CSC_FACT_LOW;
      endcase
    end
  endfunction

  // Reset image of the second control register; the divider field is sliced from it.
  localparam [7:0] CSC_CTRL2_RST_IMG = `CSC_CTRL2_RESET;

  // Software-visible control fields.
  reg  [1:0] clk_source_select_r;
  reg        ref_source_select_r;
  reg  [1:0] bus_clock_divider_r;
  reg        osc_range_r;
  reg        high_gain_r;
  reg        low_power_loop_off_r;
  reg        ext_ref_osc_request_r;
  reg        ext_ref_clock_out_en_r;
  reg        ext_ref_stop_keep_r;
  reg  [7:0] coarse_trim_r;
  reg  [1:0] osc_range_select_r;
  reg        max_freq_32k_tune_r;
  reg        fine_trim_r;
  reg        osc_ready_flag_r;
  // Pin synchronizers and the status copies that software reads.
  reg  [1:0] dbg_sync_r;
  reg  [1:0] stop_sync_r;
  reg  [1:0] osc_sync_r;
  reg  [1:0] range_sync1_r;
  reg  [1:0] range_sync2_r;
  reg        ref_sync1_r;
  reg        ref_sync2_r;
  reg  [1:0] mode_sync1_r;
  reg  [1:0] mode_sync2_r;
  reg  [1:0] mode_active_r;
  reg        stop_keep_armed_r;
  reg  [11:0] osc_init_cnt_r;
  reg  [2:0] div_cnt_r;
  reg        reset_seen_r;
  reg        out_en_prev_r;
  // Synchronized levels and decoded bus strobes.
  wire       dbg_mode;
  wire       in_stop;
  wire       osc_run;
  wire       wr_en;
  wire       rd_en;
  wire       ext_in_use;
  wire       bypass_mode;
  wire       out_en_fall;
  // Combinational helpers.
  reg  [1:0] mode_nxt;
  reg  [2:0] div_mask;
  reg  [7:0] rd_byte;
  reg        addr_ok;

  // A write needs the access phase with ready; a read is taken at setup.
  assign dbg_mode   = dbg_sync_r[1];
  assign in_stop    = stop_sync_r[1];
  assign osc_run    = osc_sync_r[1];
  assign wr_en      = i_psel & i_penable & i_pwrite & o_pready;
  assign rd_en      = i_psel & ~i_penable & ~i_pwrite;
  assign bypass_mode = (clk_source_select_r == `CSC_SRC_INT) |
                       (clk_source_select_r == `CSC_SRC_EXT);
  assign ext_in_use = ext_ref_clock_out_en_r | ~ref_source_select_r |
                      (clk_source_select_r == `CSC_SRC_EXT);
  // Enable written from one to zero, seen one cycle after the write lands.
  assign out_en_fall = out_en_prev_r & ~ext_ref_clock_out_en_r;

  // Pins from outside pass two flip-flops before any logic reads them.
  // Only the second stage is read, so a metastable first stage never leaks.
  always @(posedge i_clk) begin
    stop_sync_r <= {stop_sync_r[0], i_stop_mode};
    osc_sync_r  <= {osc_sync_r[0], i_osc_clock_signal};
    dbg_sync_r  <= {dbg_sync_r[0], i_debug_halt_mode};
  end

  // Address decode shared by read and write paths.
  always @* begin
    addr_ok = 1'b1;
    rd_byte = 8'h00;
    case (i_paddr)
      `CSC_OFF_CTRL1: rd_byte = {clk_source_select_r, 3'b000, ref_source_select_r, 2'b00};
      `CSC_OFF_CTRL2: rd_byte = {bus_clock_divider_r, osc_range_r, high_gain_r,
                                 low_power_loop_off_r, ext_ref_osc_request_r,
                                 ext_ref_clock_out_en_r, ext_ref_stop_keep_r};
      `CSC_OFF_TRIM:  rd_byte = coarse_trim_r;
      // R11 status synchronized read
      `CSC_OFF_STATUS: rd_byte = {range_sync2_r, max_freq_32k_tune_r, ref_sync2_r,
                                  mode_sync2_r, osc_ready_flag_r, fine_trim_r};
      // Read-only view of the synchronized stop and debug levels.
      `CSC_OFF_SYSIN: rd_byte = {6'b00_0000, in_stop, dbg_mode};
      default: addr_ok = 1'b0;
    endcase
  end

  // APB slave: no wait states, read data captured in setup, error on unmapped address.
  // Writes are qualified by pready, so a write lands only at the access edge.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~addr_ok;
      if (rd_en) begin
        o_prdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Control registers; trim values are loaded once after reset release.
  // A write landing in the first cycle after release is lost to the trim load.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      clk_source_select_r    <= `CSC_SRC_LOOP;
      ref_source_select_r    <= 1'b1;
      // R2 divider resets to two
      bus_clock_divider_r    <= CSC_CTRL2_RST_IMG[`CSC_CTRL2_DIV_HI:`CSC_CTRL2_DIV_LO];
      osc_range_r            <= 1'b0;
      high_gain_r            <= 1'b0;
      low_power_loop_off_r   <= 1'b0;
      ext_ref_osc_request_r  <= 1'b0;
      ext_ref_clock_out_en_r <= 1'b0;
      ext_ref_stop_keep_r    <= 1'b0;
      coarse_trim_r          <= `CSC_TRIM_DEBUG;
      osc_range_select_r     <= `CSC_RANGE_LOW;
      max_freq_32k_tune_r    <= 1'b0;
      fine_trim_r            <= `CSC_FINE_PERIOD_ADJUST_DEBUG;
      reset_seen_r           <= 1'b1;
    end else begin
      reset_seen_r <= 1'b0;
      if (reset_seen_r) begin
        // R9 coarse trim reset load
        coarse_trim_r <= dbg_mode ? `CSC_TRIM_DEBUG : i_factory_trim;
        // R22 fine trim reset load
        fine_trim_r   <= dbg_mode ? `CSC_FINE_PERIOD_ADJUST_DEBUG : i_factory_fine_period_adjust;
      end else if (wr_en && addr_ok) begin
        case (i_paddr)
          `CSC_OFF_CTRL1: begin
            // R23 reserved source ignored
            if (i_pwdata[`CSC_CTRL1_CLKSEL_HI:`CSC_CTRL1_CLKSEL_LO] != 2'b11) begin
              clk_source_select_r <= i_pwdata[`CSC_CTRL1_CLKSEL_HI:`CSC_CTRL1_CLKSEL_LO];
            end
            ref_source_select_r <= i_pwdata[`CSC_CTRL1_REFSEL];
          end
          // Plain storage; the effects of these fields are registered below.
          `CSC_OFF_CTRL2: begin
            bus_clock_divider_r    <= i_pwdata[`CSC_CTRL2_DIV_HI:`CSC_CTRL2_DIV_LO];
            osc_range_r            <= i_pwdata[`CSC_CTRL2_RANGE];
            high_gain_r            <= i_pwdata[`CSC_CTRL2_HGO];
            low_power_loop_off_r   <= i_pwdata[`CSC_CTRL2_LPOFF];
            ext_ref_osc_request_r  <= i_pwdata[`CSC_CTRL2_OSCREQ];
            ext_ref_clock_out_en_r <= i_pwdata[`CSC_CTRL2_OUTEN];
            ext_ref_stop_keep_r    <= i_pwdata[`CSC_CTRL2_STOPKEEP];
          end
          // R10 coarse trim written
          `CSC_OFF_TRIM: coarse_trim_r <= i_pwdata[7:0];
          `CSC_OFF_STATUS: begin
            // R13 locked by low power
            // R12 reserved range ignored
            if (!low_power_loop_off_r &&
                i_pwdata[`CSC_SC_RST_HI:`CSC_SC_RST_LO] != `CSC_RANGE_RSVD) begin
              osc_range_select_r <= i_pwdata[`CSC_SC_RST_HI:`CSC_SC_RST_LO];
            end
            max_freq_32k_tune_r <= i_pwdata[`CSC_SC_MAX32];
            // R21 fine trim written
            fine_trim_r         <= i_pwdata[`CSC_SC_FINE_PERIOD_ADJUST];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Active source only follows a request once the target clock is available.
  // Until then the previous mode stays active and is what the status shows.
  always @* begin
    mode_nxt = clk_source_select_r;
    if (clk_source_select_r == `CSC_SRC_EXT && !osc_run) begin
      mode_nxt = mode_active_r;
    end
  end

  // Status copies lag a write by two to three cycles, so software must poll.
  // R25 two stage status sync
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      mode_active_r <= `CSC_SRC_LOOP;
      range_sync1_r <= `CSC_RANGE_LOW;
      range_sync2_r <= `CSC_RANGE_LOW;
      ref_sync1_r   <= 1'b1;
      ref_sync2_r   <= 1'b1;
      mode_sync1_r  <= `CSC_SRC_LOOP;
      mode_sync2_r  <= `CSC_SRC_LOOP;
    end else begin
      mode_active_r <= mode_nxt;
      range_sync1_r <= osc_range_select_r;
      range_sync2_r <= range_sync1_r;
      // R17 reference status synced
      ref_sync1_r   <= ref_source_select_r;
      ref_sync2_r   <= ref_sync1_r;
      // R18 clock mode synced
      mode_sync1_r  <= mode_active_r;
      mode_sync2_r  <= mode_sync1_r;
    end
  end

  // Oscillator ready: counts init cycles while the external reference is in use,
  // through the enable, the external reference select or an external mode, with the oscillator requested.
  // It drops only when the request is low or the enable is written to zero;
  // that clear wins, since the count must then restart from a fresh start.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      osc_ready_flag_r <= 1'b0;
      osc_init_cnt_r   <= 12'd0;
      out_en_prev_r    <= 1'b0;
    end else begin
      out_en_prev_r <= ext_ref_clock_out_en_r;
      if (!ext_ref_osc_request_r || out_en_fall) begin
        // R20 clear on disable
        osc_ready_flag_r <= 1'b0;
        osc_init_cnt_r   <= 12'd0;
      end else if (ext_in_use && osc_run && !osc_ready_flag_r) begin
        // R19 set after init
        if (osc_init_cnt_r == `CSC_OSC_INIT_CYCLES) begin
          osc_ready_flag_r <= 1'b1;
        end else begin
          osc_init_cnt_r <= osc_init_cnt_r + 12'd1;
        end
      end
    end
  end

  // Divide codes map to a mask on the tick counter.
  // R1 divider mask per code
  always @* begin
    case (bus_clock_divider_r)
      2'b00:   div_mask = 3'b000;
      2'b01:   div_mask = 3'b001;
      2'b10:   div_mask = 3'b011;
      default: div_mask = 3'b111;
    endcase
  end

  // Bus enable pulses every 1, 2, 4 or 8 selected-clock ticks; divider change is immediate.
  // The counter is not restarted on a change, so the first period after it may be short.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      div_cnt_r    <= 3'd0;
      o_bus_clk_en <= 1'b0;
    end else begin
      o_bus_clk_en <= i_sel_clk_tick & ((div_cnt_r & div_mask) == 3'd0) & ~in_stop;
      if (i_sel_clk_tick) begin
        div_cnt_r <= div_cnt_r + 3'd1;
      end
    end
  end

  // Oscillator controls and loop outputs, registered.
  // Every pin-facing output is a flop, so no decode glitch reaches the oscillator.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      stop_keep_armed_r      <= 1'b0;
      o_osc_high_range       <= 1'b0;
      o_high_gain_osc_select <= 1'b0;
      o_ext_ref_osc_request  <= 1'b0;
      o_ext_ref_clock_out    <= 1'b0;
      o_ext_ref_enable       <= 1'b0;
      o_loop_enable          <= 1'b1;
      o_loop_factor          <= `CSC_FACT_LOW;
      o_controlled_osc_range <= `CSC_RANGE_LOW;
      o_coarse_trim          <= `CSC_TRIM_DEBUG;
      o_fine_period_adjust   <= `CSC_FINE_PERIOD_ADJUST_DEBUG;
    end else begin
      // Armed state is frozen on stop entry so a later enable cannot revive it.
      if (!in_stop) begin
        stop_keep_armed_r <= ext_ref_clock_out_en_r;
      end
      // R3 oscillator range
      o_osc_high_range       <= osc_range_r;
      // R4 oscillator gain
      o_high_gain_osc_select <= high_gain_r;
      // R6 reference request
      o_ext_ref_osc_request  <= ext_ref_osc_request_r;
      // R7 reference output
      o_ext_ref_clock_out    <= ext_ref_clock_out_en_r & ~in_stop;
      // R8 stop keep condition
      o_ext_ref_enable       <= in_stop ? (ext_ref_stop_keep_r & stop_keep_armed_r)
                                        : ext_in_use;
      // R5 R24 loop disable in bypass
      o_loop_enable          <= ~in_stop & ~(bypass_mode & low_power_loop_off_r & ~dbg_mode);
      // R14 R15 R16 factor lookup
      o_loop_factor          <= csc_factor(range_sync2_r, max_freq_32k_tune_r);
      o_controlled_osc_range <= range_sync2_r;
      o_coarse_trim          <= coarse_trim_r;
      o_fine_period_adjust   <= fine_trim_r;
    end
  end

endmodule // csc_clock_source_ctrl

// [csc_monitor.sv]
// Port level assertions for the clock source control block.
`timescale 1ns/1ns
`include "csc_regs.vh"
module csc_monitor (
  input wire        i_clk,               // Block clock.
  input wire        i_rst_n,             // Reset, active low.
  input wire        i_psel,              // APB select.
  input wire        i_penable,           // APB enable.
  input wire        i_debug_halt_mode,   // Debug pin.
  input wire        i_stop_mode,         // Stop pin.
  input wire        i_sel_clk_tick,      // Source clock tick.
  input wire [31:0] o_prdata,            // Read data.
  input wire        o_pready,            // Ready.
  input wire        o_pslverr,           // Error response.
  input wire        o_bus_clk_en,        // Bus clock pulse.
  input wire        o_ext_ref_clock_out, // Reference clock out.
  input wire        o_loop_enable,       // Loop enable.
  input wire [10:0] o_loop_factor,       // Loop factor.
  input wire [1:0]  o_controlled_osc_range // Applied range.
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Pins are synchronized first, so only levels held for several cycles are judged.
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_debug_run;
    (i_debug_halt_mode && !i_stop_mode) [*5];
  endsequence
  sequence s_stop_held;
    i_stop_mode [*5];
  endsequence
  chk_apb_ready_next: assert property (s_setup |=> o_pready)
    else $error("ready missing after setup");
  chk_ready_one_cycle: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  chk_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  chk_rdata_upper_zero: assert property (o_prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  chk_bus_pulse_tick: assert property (o_bus_clk_en |-> $past(i_sel_clk_tick))
    else $error("bus pulse without tick");
  chk_debug_loop_on: assert property (s_debug_run |-> o_loop_enable)
    else $error("loop off in debug");
  chk_stop_loop_off: assert property (s_stop_held |-> !o_loop_enable)
    else $error("loop on in stop");
  chk_stop_out_idle: assert property (s_stop_held |-> !o_ext_ref_clock_out)
    else $error("reference out active in stop");
  chk_factor_legal: assert property (o_loop_factor inside {`CSC_FACT_LOW, `CSC_FACT_MID,
    `CSC_FACT_HIGH, `CSC_FACT32_LOW, `CSC_FACT32_MID, `CSC_FACT32_HIGH})
    else $error("illegal loop factor");
  chk_range_not_rsvd: assert property (o_controlled_osc_range != 2'b11)
    else $error("reserved range applied");
endmodule // csc_monitor

bind csc_clock_source_ctrl csc_monitor i_mon (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_debug_halt_mode(i_debug_halt_mode), .i_stop_mode(i_stop_mode),
  .i_sel_clk_tick(i_sel_clk_tick), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_bus_clk_en(o_bus_clk_en),
  .o_ext_ref_clock_out(o_ext_ref_clock_out), .o_loop_enable(o_loop_enable),
  .o_loop_factor(o_loop_factor), .o_controlled_osc_range(o_controlled_osc_range));

// [csc_regs.vh]
// Register offsets, field positions, reset values and constants of the clock source control block.
`ifndef CSC_REGS_VH
`define CSC_REGS_VH
`define CSC_OFF_CTRL1        12'h000
`define CSC_OFF_CTRL2        12'h004
`define CSC_OFF_TRIM         12'h008
`define CSC_OFF_STATUS       12'h00C
`define CSC_OFF_SYSIN        12'h010
`define CSC_CTRL1_CLKSEL_HI  7
`define CSC_CTRL1_CLKSEL_LO  6
`define CSC_CTRL1_REFSEL     2
`define CSC_CTRL1_RESET      8'h04
`define CSC_CTRL2_DIV_HI     7
`define CSC_CTRL2_DIV_LO     6
`define CSC_CTRL2_RANGE      5
`define CSC_CTRL2_HGO        4
`define CSC_CTRL2_LPOFF      3
`define CSC_CTRL2_OSCREQ     2
`define CSC_CTRL2_OUTEN      1
`define CSC_CTRL2_STOPKEEP   0
`define CSC_CTRL2_RESET      8'h40
`define CSC_TRIM_DEBUG       8'h80
`define CSC_FINE_PERIOD_ADJUST_DEBUG      1'b0
`define CSC_SC_RST_HI        7
`define CSC_SC_RST_LO        6
`define CSC_SC_MAX32         5
`define CSC_SC_REFST         4
`define CSC_SC_CLOCK_MODE_STATUS_HI      3
`define CSC_SC_CLOCK_MODE_STATUS_LO      2
`define CSC_SC_OSCRDY        1
`define CSC_SC_FINE_PERIOD_ADJUST         0
`define CSC_RANGE_LOW        2'b00
`define CSC_RANGE_MID        2'b01
`define CSC_RANGE_HIGH       2'b10
`define CSC_RANGE_RSVD       2'b11
`define CSC_SRC_LOOP         2'b00
`define CSC_SRC_INT          2'b01
`define CSC_SRC_EXT          2'b10
`define CSC_FACT_LOW         11'd512
`define CSC_FACT_MID         11'd1024
`define CSC_FACT_HIGH        11'd1536
`define CSC_FACT32_LOW       11'd608
`define CSC_FACT32_MID       11'd1216
`define CSC_FACT32_HIGH      11'd1824
`define CSC_OSC_INIT_CYCLES  12'd4095
`endif

// [tb_clock_source_ctrl_status.sv]
// Register level testbench for the clock source control block.
`timescale 1ns/1ns
`include "csc_regs.vh"
module tb_clock_source_ctrl_status;
  reg         i_clk, i_rst_n, i_psel, i_penable, i_pwrite;
  reg  [11:0] i_paddr;
  reg  [31:0] i_pwdata;
  reg         i_debug_halt_mode, i_stop_mode, i_osc_clock_signal, i_sel_clk_tick;
  wire [31:0] o_prdata;
  wire        o_pready, o_pslverr, o_bus_clk_en, o_osc_high_range, o_high_gain_osc_select;
  wire        o_ext_ref_osc_request, o_ext_ref_clock_out, o_ext_ref_enable, o_loop_enable;
  wire [10:0] o_loop_factor;
  wire [1:0]  o_controlled_osc_range;
  wire [7:0]  o_coarse_trim;
  wire        o_fine_period_adjust;
  reg  [31:0] q, cnt, cyc, t0;
  reg         last_err, tune_v;
  reg  [1:0]  rng_v;
  integer     err_total, n_compared, i, k;

  csc_clock_source_ctrl i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_debug_halt_mode(i_debug_halt_mode), .i_stop_mode(i_stop_mode),
    .i_osc_clock_signal(i_osc_clock_signal), .i_factory_trim(8'h3C),
    .i_factory_fine_period_adjust(1'b1), .i_sel_clk_tick(i_sel_clk_tick), .o_bus_clk_en(o_bus_clk_en),
    .o_osc_high_range(o_osc_high_range), .o_high_gain_osc_select(o_high_gain_osc_select),
    .o_ext_ref_osc_request(o_ext_ref_osc_request), .o_ext_ref_clock_out(o_ext_ref_clock_out),
    .o_ext_ref_enable(o_ext_ref_enable), .o_loop_enable(o_loop_enable),
    .o_loop_factor(o_loop_factor), .o_controlled_osc_range(o_controlled_osc_range),
    .o_coarse_trim(o_coarse_trim), .o_fine_period_adjust(o_fine_period_adjust));

  // Clock of 100 ns period.
  always #50 i_clk = ~i_clk;
  // Source tick every second cycle and a free cycle count for elapsed-time checks.
  always @(posedge i_clk) begin
    i_sel_clk_tick <= ~i_sel_clk_tick;
    cyc <= cyc + 1;
  end

  task tally_and_finish;
    begin
      if (err_total == 0 && n_compared > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  // One APB transfer; the request stands until ready is sampled high.
  task apb(input w, input [11:0] a, input [7:0] d);
    begin
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= {24'h00_0000, d};
      @(posedge i_clk);
      i_penable <= 1'b1;
      @(posedge i_clk);
      for (k = 0; k < 20 && o_pready !== 1'b1; k = k + 1)
        @(posedge i_clk);
      if (k == 20) begin
        err_total = err_total + 1;
        tally_and_finish;
      end
      q = o_prdata;
      last_err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
    end
  endtask

  task rd_chk(input [11:0] a, input [7:0] m, input [7:0] e);
    begin
      apb(1'b0, a, 8'h00);
      chk(q & {24'h00_0000, m}, {24'h00_0000, e});
    end
  endtask

  initial begin
    i_clk = 0; i_rst_n = 0; i_psel = 0; i_penable = 0; i_pwrite = 0; i_paddr = 0;
    i_pwdata = 0; i_debug_halt_mode = 0; i_stop_mode = 0; i_osc_clock_signal = 0;
    i_sel_clk_tick = 0; cyc = 0; err_total = 0; n_compared = 0; last_err = 0;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd_chk(`CSC_OFF_CTRL1, 8'hFF, `CSC_CTRL1_RESET);
    rd_chk(`CSC_OFF_CTRL2, 8'hFF, 8'h40);
    rd_chk(`CSC_OFF_TRIM, 8'hFF, 8'h3C);
    rd_chk(`CSC_OFF_STATUS, 8'hFF, 8'h11);
    chk(last_err, 0);
    apb(1'b0, 12'h0FC, 8'h00);
    chk(last_err, 1);
    // pulses over 48 ticks must match each divide ratio within one.
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, `CSC_OFF_CTRL2, {i[1:0], 6'h00});
      cnt = 0;
      repeat (96) begin
        @(posedge i_clk);
        if (o_bus_clk_en === 1'b1) cnt = cnt + 1;
      end
      chk(cnt + 1 >= (48 >> i) && cnt <= (48 >> i) + 1, 1);
    end
    apb(1'b1, `CSC_OFF_CTRL2, 8'h74);
    repeat (2) @(posedge i_clk);
    chk({o_osc_high_range, o_high_gain_osc_select, o_ext_ref_osc_request,
         o_ext_ref_clock_out}, 4'b1110);
    apb(1'b1, `CSC_OFF_CTRL2, 8'h42);
    repeat (2) @(posedge i_clk);
    chk({o_osc_high_range, o_high_gain_osc_select, o_ext_ref_osc_request,
         o_ext_ref_clock_out}, 4'b0001);
    apb(1'b1, `CSC_OFF_TRIM, 8'hA5);
    rd_chk(`CSC_OFF_TRIM, 8'hFF, 8'hA5);
    chk(o_coarse_trim, 8'hA5);
    apb(1'b1, `CSC_OFF_STATUS, 8'h00);
    repeat (2) @(posedge i_clk);
    chk(o_fine_period_adjust, 0);
    // every legal range with tuning off and on.
    for (i = 0; i < 6; i = i + 1) begin
      rng_v  = i[1:0] - ((i >= 3) ? 2'd3 : 2'd0);
      tune_v = (i >= 3);
      apb(1'b1, `CSC_OFF_STATUS, {rng_v, tune_v, 5'h01});
      repeat (6) @(posedge i_clk);
      rd_chk(`CSC_OFF_STATUS, 8'hE1, {rng_v, tune_v, 5'h01});
      chk(o_loop_factor, (tune_v ? 608 : 512) * (rng_v + 1));
      chk(o_controlled_osc_range, rng_v);
    end
    apb(1'b1, `CSC_OFF_STATUS, 8'hE0);
    repeat (6) @(posedge i_clk);
    rd_chk(`CSC_OFF_STATUS, 8'hC0, 8'h80);
    chk(o_loop_factor, 1824);
    apb(1'b1, `CSC_OFF_CTRL1, 8'h44);
    apb(1'b1, `CSC_OFF_CTRL2, 8'h48);
    apb(1'b1, `CSC_OFF_STATUS, 8'h40);
    repeat (6) @(posedge i_clk);
    rd_chk(`CSC_OFF_STATUS, 8'hDC, 8'h94);
    chk(o_loop_enable, 0);
    i_debug_halt_mode <= 1'b1;
    repeat (6) @(posedge i_clk);
    chk(o_loop_enable, 1);
    i_debug_halt_mode <= 1'b0;
    apb(1'b1, `CSC_OFF_CTRL1, 8'h00);
    apb(1'b1, `CSC_OFF_CTRL2, 8'h43);
    repeat (6) @(posedge i_clk);
    rd_chk(`CSC_OFF_STATUS, 8'h1C, 8'h00);
    i_stop_mode <= 1'b1;
    repeat (6) @(posedge i_clk);
    chk({o_ext_ref_enable, o_ext_ref_clock_out, o_loop_enable}, 3'b100);
    i_stop_mode <= 1'b0;
    apb(1'b1, `CSC_OFF_CTRL2, 8'h41);
    i_stop_mode <= 1'b1;
    repeat (6) @(posedge i_clk);
    chk(o_ext_ref_enable, 0);
    i_stop_mode <= 1'b0;
    // ready only after the oscillator start count, cleared with the enable.
    i_osc_clock_signal <= 1'b1;
    apb(1'b1, `CSC_OFF_CTRL2, 8'h46);
    t0 = cyc;
    rd_chk(`CSC_OFF_STATUS, 8'h02, 8'h00);
    for (i = 0; i < 3000 && q[1] !== 1'b1; i = i + 1)
      apb(1'b0, `CSC_OFF_STATUS, 8'h00);
    chk(q[1] === 1'b1 && cyc - t0 >= 4095, 1);
    apb(1'b1, `CSC_OFF_CTRL2, 8'h44);
    repeat (4) @(posedge i_clk);
    rd_chk(`CSC_OFF_STATUS, 8'h02, 8'h00);
    // with the enable off, the external reference select still gets the flag set.
    for (i = 0; i < 3000 && q[1] !== 1'b1; i = i + 1)
      apb(1'b0, `CSC_OFF_STATUS, 8'h00);
    chk(q[1], 1);
    apb(1'b1, `CSC_OFF_CTRL1, 8'h80);
    repeat (6) @(posedge i_clk);
    rd_chk(`CSC_OFF_STATUS, 8'h1C, 8'h08);
    apb(1'b1, `CSC_OFF_CTRL1, 8'hC0);
    repeat (6) @(posedge i_clk);
    rd_chk(`CSC_OFF_STATUS, 8'h1C, 8'h08);
    i_debug_halt_mode <= 1'b1;
    i_rst_n <= 1'b0;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd_chk(`CSC_OFF_TRIM, 8'hFF, `CSC_TRIM_DEBUG);
    rd_chk(`CSC_OFF_STATUS, 8'h01, 8'h00);
    tally_and_finish;
  end
endmodule // tb_clock_source_ctrl_status
